//--- core/swp_slave.sv
// module: device end of the single-wire programming link
`timescale 1ns/1ps
`default_nettype none
module swp_slave #(
   parameter int TMO_CYC    = swp_pkg::TMO_CYC,
   parameter int GLITCH_CYC = swp_pkg::GLITCH_CYC
) (
   input  wire logic                         ref_clk_in,
   input  wire logic                         rst_in,
   swp_if.slave                              link,
   output logic [swp_pkg::ADDR_W-1:0]        acc_addr_out,
   output logic                              storage_block_select_out,
   output logic [swp_pkg::WORD_W-1:0]        wr_data_out,
   output logic                              wr_stb_out,
   output logic                              rd_stb_out,
   input  wire logic [swp_pkg::WORD_W-1:0]   rd_data_in,
   output logic                              act_stb_out,
   output logic [swp_pkg::BYTE_W-1:0]        act_code_out,
   output logic                              busy_out
);
   import swp_pkg::*;

   logic                 rise;
   logic                 fall;
   logic                 rx_bit;
   logic                 stop;
   logic                 tmo;
   logic [CW-1:0]        period;
   logic [CW-1:0]        since_rise;
   swp_slv_state_e       state_r;
   logic [DATA_BITS-1:0] shf_r;
   logic [DATA_BITS-1:0] shf_nxt;
   logic [CMD_BITS-1:0]  cmd9;
   logic [DATA_BITS:0]   tx_r;
   logic [4:0]           nbit_r;
   logic [CW-1:0]        tcnt_r;
   logic [CW-1:0]        quarter;
   logic [CW-1:0]        last_tick;
   logic [CW-1:0]        hi_end;
   logic                 wok_r;
   logic                 o_r;
   logic                 oe_r;
   logic                 cmd_done;
   logic                 bit_end;

   swp_bit_rx #(
      .CW         (CW),
      .GLITCH_CYC (GLITCH_CYC),
      .TMO_CYC    (TMO_CYC)
   ) u_rx (
      .ref_clk_in     (ref_clk_in),
      .rst_in         (rst_in),
      .line_in        (link.line),
      .rise_out       (rise),
      .fall_out       (fall),
      .bit_out        (rx_bit),
      .stop_out       (stop),
      .tmo_out        (tmo),
      .period_out     (period),
      .since_rise_out (since_rise)
   );

   assign shf_nxt   = {shf_r[DATA_BITS-2:0], rx_bit};
   assign cmd9      = shf_nxt[CMD_BITS-1:0];
   assign quarter   = period >> SEG_SHIFT;
   assign last_tick = period - 1'b1;
   assign hi_end    = period - quarter;
   assign cmd_done  = state_r == S_CMD && fall && nbit_r == 5'(CMD_BITS - 1);
   assign bit_end   = tcnt_r == last_tick;

   // protocol sequencer
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= S_IDLE;
      end else if (tmo && state_r != S_IDLE) begin
         state_r <= S_IDLE;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (rise) state_r <= S_START;
            end
            S_START: begin
               if (rise) state_r <= S_CMD;
            end
            S_CMD: begin
               if (stop) begin
                  state_r <= S_IDLE;
               end else if (cmd_done) begin
                  if (cmd9[CMD_BITS-1] != swp_par_f(cmd9[BYTE_W-1:0])) begin
                     state_r <= S_DROP;
                  end else if (!cmd9[CMD_DATA_BIT]) begin
                     state_r <= S_ASTOP;
                  end else if (cmd9[CMD_RD_BIT]) begin
                     state_r <= S_TAKE;
                  end else begin
                     state_r <= S_WDATA;
                  end
               end
            end
            S_WDATA: begin
               if (stop) begin
                  state_r <= S_IDLE;
               end else if (fall && nbit_r == 5'(DATA_BITS - 1)) begin
                  state_r <= S_WSTOP;
               end
            end
            S_WSTOP, S_ASTOP: begin
               if (stop) begin
                  state_r <= S_IDLE;
               end else if (fall) begin
                  state_r <= S_DROP;
               end
            end
            S_TAKE: begin
               if (fall) state_r <= S_TBIT;
            end
            S_TBIT: begin
               if (since_rise >= last_tick) state_r <= S_TX;
            end
            S_TX: begin
               if (bit_end && nbit_r == 5'(DATA_BITS)) state_r <= S_DROP;
            end
            S_DROP: begin
               if (stop) state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // bit counter and transmit timer
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         nbit_r <= 5'h0;
         tcnt_r <= '0;
      end else begin
         case (state_r)
            S_CMD: begin
               if (cmd_done) nbit_r <= 5'h0;
               else if (fall) nbit_r <= nbit_r + 1'b1;
               tcnt_r <= '0;
            end
            S_WDATA: begin
               if (fall) nbit_r <= nbit_r + 1'b1;
               tcnt_r <= '0;
            end
            S_TX: begin
               if (bit_end) begin
                  nbit_r <= nbit_r + 1'b1;
                  tcnt_r <= '0;
               end else begin
                  tcnt_r <= tcnt_r + 1'b1;
               end
            end
            default: begin
               nbit_r <= 5'h0;
               tcnt_r <= '0;
            end
         endcase
      end
   end

   // shift registers and captured fields
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         shf_r                    <= '0;
         tx_r                     <= '0;
         wok_r                    <= 1'b0;
         wr_data_out              <= '0;
         acc_addr_out             <= '0;
         storage_block_select_out <= 1'b0;
         act_code_out             <= '0;
      end else begin
         if (fall && (state_r == S_CMD || state_r == S_WDATA)) begin
            shf_r <= shf_nxt;
         end
         if (cmd_done) begin
            acc_addr_out             <= cmd9[ADDR_W-1:0];
            storage_block_select_out <= cmd9[CMD_NV_BIT];
            act_code_out             <= cmd9[BYTE_W-1:0];
         end
         if (state_r == S_WDATA && fall && nbit_r == 5'(DATA_BITS - 1)) begin
            wok_r       <= swp_frame_ok_f(shf_nxt);
            wr_data_out <= swp_word_f(shf_nxt);
         end
         if (state_r == S_TBIT) begin
            tx_r <= {swp_frame_f(rd_data_in), 1'b0};
         end else if (state_r == S_TX && bit_end) begin
            tx_r <= {tx_r[DATA_BITS-1:0], 1'b0};
         end
      end
   end

   // wire driver
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         o_r  <= 1'b0;
         oe_r <= 1'b0;
      end else if (tmo) begin
         o_r  <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         case (state_r)
            S_TAKE: begin
               o_r  <= 1'b0;
               oe_r <= fall;
            end
            S_TBIT: begin
               o_r  <= 1'b0;
               oe_r <= 1'b1;
            end
            S_TX: begin
               if (tcnt_r < quarter) o_r <= 1'b1;
               else if (tcnt_r < hi_end) o_r <= tx_r[DATA_BITS];
               else o_r <= 1'b0;
               oe_r <= !(nbit_r == 5'(DATA_BITS) && tcnt_r >= hi_end);
            end
            default: begin
               o_r  <= 1'b0;
               oe_r <= 1'b0;
            end
         endcase
      end
   end

   // access strobes
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_stb_out  <= 1'b0;
         rd_stb_out  <= 1'b0;
         act_stb_out <= 1'b0;
      end else begin
         wr_stb_out  <= !tmo && state_r == S_WSTOP && stop && wok_r;
         act_stb_out <= !tmo && state_r == S_ASTOP && stop;
         rd_stb_out  <= !tmo && cmd_done && cmd9[CMD_DATA_BIT] && cmd9[CMD_RD_BIT]
                        && cmd9[CMD_BITS-1] == swp_par_f(cmd9[BYTE_W-1:0]);
      end
   end

   assign link.slv_o  = o_r;
   assign link.slv_oe = oe_r;
   assign busy_out    = state_r != S_IDLE;
endmodule : swp_slave
`default_nettype wire

//--- pkg/swp_pkg.sv
// package: constants, types and helpers for the single-wire programming link
package swp_pkg;
   localparam int CLK_NS       = 25;
   localparam int SEGS         = 4;
   localparam int SEG_SHIFT    = 2;
   localparam int MAX_BIT_NS   = 100000;
   localparam int TMO_NS       = 2 * MAX_BIT_NS;
   localparam int TMO_CYC      = TMO_NS / CLK_NS;
   localparam int GLITCH_NS    = 100;
   localparam int GLITCH_CYC   = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int MST_BIT_NS   = 10000;
   localparam int MST_SEG_CYC  = (MST_BIT_NS / SEGS + CLK_NS - 1) / CLK_NS;
   localparam int EXEC_NS      = 15000000;
   localparam int EXEC_CYC     = (EXEC_NS + CLK_NS - 1) / CLK_NS;
   localparam int STOP_BITS    = 2;
   localparam int CW           = 16;
   localparam int MCW          = 24;
   localparam int BYTE_W       = 8;
   localparam int WORD_W       = 16;
   localparam int ADDR_W       = 5;
   localparam int CMD_BITS     = 9;
   localparam int DATA_BITS    = 18;
   localparam int TXV_W        = 1 + CMD_BITS + DATA_BITS;
   localparam int CMD_DATA_BIT = 7;
   localparam int CMD_RD_BIT   = 6;
   localparam int CMD_NV_BIT   = 5;

   typedef enum logic [3:0] {
      S_IDLE  = 4'h0, S_START = 4'h1, S_CMD  = 4'h2, S_WDATA = 4'h3,
      S_WSTOP = 4'h4, S_ASTOP = 4'h5, S_TAKE = 4'h6, S_TBIT  = 4'h7,
      S_TX    = 4'h8, S_DROP  = 4'h9
   } swp_slv_state_e;

   typedef enum logic [2:0] {
      M_IDLE = 3'h0, M_SEND = 3'h1, M_STOP = 3'h2, M_EXEC = 3'h3,
      M_RX   = 3'h4, M_TBIT = 3'h5
   } swp_mst_state_e;

   // even parity bit over one byte
   function automatic logic swp_par_f(input logic [BYTE_W-1:0] b);
      return ^b;
   endfunction : swp_par_f

   // upper parity, upper byte, lower parity, lower byte
   function automatic logic [DATA_BITS-1:0] swp_frame_f(input logic [WORD_W-1:0] w);
      return {swp_par_f(w[15:8]), w[15:8], swp_par_f(w[7:0]), w[7:0]};
   endfunction : swp_frame_f

   function automatic logic swp_frame_ok_f(input logic [DATA_BITS-1:0] f);
      return (f[17] == swp_par_f(f[16:9])) && (f[8] == swp_par_f(f[7:0]));
   endfunction : swp_frame_ok_f

   function automatic logic [WORD_W-1:0] swp_word_f(input logic [DATA_BITS-1:0] f);
      return {f[16:9], f[7:0]};
   endfunction : swp_word_f
endpackage : swp_pkg

//--- pkg/swp_if.sv
// interface: the shared programming wire and both drivers
`timescale 1ns/1ps
`default_nettype none
interface swp_if;
   logic mst_o;
   logic mst_oe;
   logic slv_o;
   logic slv_oe;
   logic line;

   // undriven wire reads low
   assign line = (mst_oe & mst_o) | (slv_oe & slv_o);

   modport master (output mst_o, output mst_oe, input line);
   modport slave  (output slv_o, output slv_oe, input line);
endinterface : swp_if
`default_nettype wire

//--- core/swp_bit_rx.sv
// module: wire receiver, glitch filter, edge timing and bit decode
`timescale 1ns/1ps
`default_nettype none
module swp_bit_rx #(
   parameter int CW         = swp_pkg::CW,
   parameter int GLITCH_CYC = swp_pkg::GLITCH_CYC,
   parameter int TMO_CYC    = swp_pkg::TMO_CYC
) (
   input  wire logic          ref_clk_in,
   input  wire logic          rst_in,
   input  wire logic          line_in,
   output logic               rise_out,
   output logic               fall_out,
   output logic               bit_out,
   output logic               stop_out,
   output logic               tmo_out,
   output logic [CW-1:0]      period_out,
   output logic [CW-1:0]      since_rise_out
);
   import swp_pkg::*;
   logic [2:0]    sync_r;
   logic [CW-1:0] gcnt_r;
   logic          filt_r;
   logic          prev_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] per_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_r <= 3'h0;
         gcnt_r <= '0;
         filt_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], line_in};
         prev_r <= filt_r;
         if (sync_r[1] == sync_r[2] && sync_r[2] != filt_r) begin
            if (gcnt_r == CW'(GLITCH_CYC - 1)) begin
               filt_r <= sync_r[2];
               gcnt_r <= '0;
            end else begin
               gcnt_r <= gcnt_r + 1'b1;
            end
         end else begin
            gcnt_r <= '0;
         end
      end
   end

   assign rise_out = filt_r & ~prev_r;
   assign fall_out = ~filt_r & prev_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= '1;
         per_r <= '1;
      end else if (rise_out) begin
         cnt_r <= '0;
         per_r <= cnt_r + 1'b1;
      end else if (cnt_r != '1) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign bit_out        = cnt_r > (per_r >> 1);
   assign stop_out       = filt_r && cnt_r == per_r + (per_r >> SEG_SHIFT);
   assign tmo_out        = cnt_r >= CW'(TMO_CYC);
   assign period_out     = per_r;
   assign since_rise_out = cnt_r;
endmodule : swp_bit_rx
`default_nettype wire

//--- core/swp_master.sv
// module: host end of the single-wire programming link
`timescale 1ns/1ps
`default_nettype none
module swp_master #(
   parameter int SEG_CYC  = swp_pkg::MST_SEG_CYC,
   parameter int EXEC_CYC = swp_pkg::EXEC_CYC
) (
   input  wire logic                         ref_clk_in,
   input  wire logic                         rst_in,
   swp_if.master                             link,
   input  wire logic                         go_in,
   input  wire logic [swp_pkg::BYTE_W-1:0]   cmd_in,
   input  wire logic [swp_pkg::WORD_W-1:0]   wdata_in,
   output logic                              busy_out,
   output logic                              done_out,
   output logic                              err_out,
   output logic [swp_pkg::WORD_W-1:0]        rdata_out
);
   import swp_pkg::*;
   localparam logic [MCW-1:0] SEG_L  = MCW'(SEG_CYC - 1);
   localparam logic [MCW-1:0] MID_L  = MCW'(2 * SEG_CYC);
   localparam logic [MCW-1:0] BIT_L  = MCW'(SEGS * SEG_CYC - 1);
   localparam logic [MCW-1:0] RXTO_L = MCW'(2 * SEGS * SEG_CYC);
   localparam logic [MCW-1:0] STOP_L = MCW'(STOP_BITS * SEGS * SEG_CYC - 1);
   localparam logic [MCW-1:0] GAP_L  = MCW'((STOP_BITS * SEGS + SEGS) * SEG_CYC - 1);
   localparam logic [MCW-1:0] EXEC_L = MCW'(EXEC_CYC - 1);

   swp_mst_state_e       state_r;
   logic [2:0]           sync_r;
   logic                 filt_r;
   logic                 prev_r;
   logic                 rise;
   logic                 fall;
   logic [TXV_W-1:0]     txv_r;
   logic [4:0]           nleft_r;
   logic [1:0]           seg_r;
   logic [MCW-1:0]       scnt_r;
   logic [MCW-1:0]       wcnt_r;
   logic [4:0]           rxn_r;
   logic [DATA_BITS-1:0] rxsh_r;
   logic                 rd_r;
   logic                 nvw_r;
   logic                 o_r;
   logic                 oe_r;

   assign rise = filt_r & ~prev_r;
   assign fall = ~filt_r & prev_r;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync_r <= 3'h0;
         filt_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], link.line};
         if (sync_r[1] == sync_r[2]) filt_r <= sync_r[2];
         prev_r <= filt_r;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r   <= M_IDLE;
         txv_r     <= '0;
         nleft_r   <= 5'h0;
         seg_r     <= 2'h0;
         scnt_r    <= '0;
         wcnt_r    <= '0;
         rxn_r     <= 5'h0;
         rxsh_r    <= '0;
         rd_r      <= 1'b0;
         nvw_r     <= 1'b0;
         o_r       <= 1'b0;
         oe_r      <= 1'b1;
         done_out  <= 1'b0;
         err_out   <= 1'b0;
         rdata_out <= '0;
      end else begin
         done_out <= 1'b0;
         err_out  <= 1'b0;
         case (state_r)
            M_IDLE: begin
               o_r  <= 1'b0;
               oe_r <= 1'b1;
               if (go_in) begin
                  rd_r  <= cmd_in[CMD_DATA_BIT] & cmd_in[CMD_RD_BIT];
                  nvw_r <= cmd_in[CMD_DATA_BIT] & ~cmd_in[CMD_RD_BIT] & cmd_in[CMD_NV_BIT];
                  txv_r <= {1'b1, swp_par_f(cmd_in), cmd_in,
                            cmd_in[CMD_RD_BIT] ? DATA_BITS'(0) : swp_frame_f(wdata_in)};
                  if (!cmd_in[CMD_DATA_BIT]) nleft_r <= 5'(1 + CMD_BITS);
                  else if (cmd_in[CMD_RD_BIT]) nleft_r <= 5'(2 + CMD_BITS);
                  else nleft_r <= 5'(TXV_W);
                  seg_r   <= 2'h0;
                  scnt_r  <= '0;
                  state_r <= M_SEND;
               end
            end
            M_SEND: begin
               if (seg_r == 2'h0) o_r <= 1'b1;
               else if (seg_r == 2'h3) o_r <= 1'b0;
               else o_r <= txv_r[TXV_W-1];
               if (scnt_r == SEG_L) begin
                  scnt_r <= '0;
                  seg_r  <= seg_r + 1'b1;
                  if (rd_r && nleft_r == 5'h1 && seg_r == 2'h2) begin
                     oe_r    <= 1'b0;
                     wcnt_r  <= '0;
                     rxn_r   <= 5'h0;
                     state_r <= M_RX;
                  end else if (seg_r == 2'h3) begin
                     txv_r   <= {txv_r[TXV_W-2:0], 1'b0};
                     nleft_r <= nleft_r - 1'b1;
                     if (nleft_r == 5'h1) begin
                        wcnt_r  <= '0;
                        state_r <= M_STOP;
                     end
                  end
               end else begin
                  scnt_r <= scnt_r + 1'b1;
               end
            end
            M_STOP: begin
               // stop high, then one low bit time so the next start is seen
               o_r    <= wcnt_r < STOP_L;
               wcnt_r <= wcnt_r + 1'b1;
               if (wcnt_r == GAP_L) begin
                  wcnt_r   <= '0;
                  state_r  <= nvw_r ? M_EXEC : M_IDLE;
                  done_out <= !nvw_r;
               end
            end
            M_EXEC: begin
               wcnt_r <= wcnt_r + 1'b1;
               if (wcnt_r == EXEC_L) begin
                  state_r  <= M_IDLE;
                  done_out <= 1'b1;
               end
            end
            M_RX: begin
               wcnt_r <= rise ? '0 : wcnt_r + 1'b1;
               if (rise) rxn_r <= rxn_r + 1'b1;
               if (wcnt_r == MID_L && rxn_r != 5'h0 && rxn_r <= 5'(DATA_BITS)) begin
                  rxsh_r <= {rxsh_r[DATA_BITS-2:0], filt_r};
               end
               if (fall && rxn_r == 5'(DATA_BITS + 1)) begin
                  o_r     <= 1'b0;
                  oe_r    <= 1'b1;
                  state_r <= M_TBIT;
               end else if (wcnt_r == RXTO_L) begin
                  oe_r    <= 1'b1;
                  o_r     <= 1'b0;
                  err_out <= 1'b1;
                  state_r <= M_IDLE;
               end
            end
            M_TBIT: begin
               wcnt_r <= wcnt_r + 1'b1;
               if (wcnt_r >= BIT_L) begin
                  rdata_out <= swp_word_f(rxsh_r);
                  err_out   <= !swp_frame_ok_f(rxsh_r);
                  wcnt_r    <= '0;
                  state_r   <= M_STOP;
               end
            end
            default: state_r <= M_IDLE;
         endcase
      end
   end

   assign link.mst_o  = o_r;
   assign link.mst_oe = oe_r;
   assign busy_out    = state_r != M_IDLE;
endmodule : swp_master
`default_nettype wire

//--- dv/swp_assertions.sv
// checker: wire-level properties of the programming link
`timescale 1ns/1ps
`default_nettype none
module swp_assertions (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic mst_o,
   input wire logic mst_oe,
   input wire logic slv_o,
   input wire logic slv_oe,
   input wire logic line
);
   logic       line_q;
   logic [7:0] gap_r;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // cycles since the last rise, saturating
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) line_q <= 1'b0;
      else line_q <= line;
   end
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) gap_r <= 8'hff;
      else if (line && !line_q) gap_r <= 8'h01;
      else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
   end
   property p_no_clash; mst_oe && slv_oe |-> !mst_o && !slv_o; endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive");
   property p_take_free; $rose(slv_oe) |-> !mst_o && !$past(line); endproperty
   a_take_free: assert property (p_take_free) else $error("takeover on high wire");
   property p_take_low; $rose(slv_oe) |-> !slv_o [*2]; endproperty
   a_take_low: assert property (p_take_low) else $error("takeover not low");
   property p_mst_hand; $fell(mst_oe) |-> !$past(mst_o) && !line; endproperty
   a_mst_hand: assert property (p_mst_hand) else $error("host release not low");
   property p_slv_hand; $fell(slv_oe) |-> !$past(slv_o); endproperty
   a_slv_hand: assert property (p_slv_hand) else $error("device release not low");
   property p_back; $fell(slv_oe) |-> mst_oe; endproperty
   a_back: assert property (p_back) else $error("host not driving on release");
   property p_high; $rose(line) |-> line [*8]; endproperty
   a_high: assert property (p_high) else $error("first segment short");
   property p_low; $fell(line) |-> !line [*8]; endproperty
   a_low: assert property (p_low) else $error("low segment short");
   property p_period; $rose(line) |-> gap_r >= 8'h20; endproperty
   a_period: assert property (p_period) else $error("rises too close");
   c_take: cover property ($rose(slv_oe));
   c_hand: cover property ($fell(slv_oe));
   c_bit: cover property ($rose(line));
endmodule : swp_assertions
`default_nettype wire

//--- dv/testbench.sv
// testbench: both link ends joined, driven from the host user port
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import swp_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic        go         = 1'b0;
   logic [7:0]  cmd        = 8'h00;
   logic [15:0] wd         = 16'h0000;
   logic [15:0] rdd        = 16'h0000;
   logic        done, err, wr_stb, rd_stb, act_stb, bsel;
   logic        mbusy, sbusy;
   logic [4:0]  addr;
   logic [7:0]  act_code;
   logic [15:0] rdata, wr_data;
   logic [31:0] sh;
   int          hi_n, n_wr, n_rd, n_act, n_err, cyc, miscompares, comparisons;
   swp_if link ();
   swp_master #(.SEG_CYC(10), .EXEC_CYC(50)) u_swp_master (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .link(link), .go_in(go), .cmd_in(cmd), .wdata_in(wd),
      .busy_out(mbusy), .done_out(done), .err_out(err), .rdata_out(rdata));
   swp_slave #(.TMO_CYC(400), .GLITCH_CYC(GLITCH_CYC)) u_swp_slave (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .link(link), .acc_addr_out(addr), .storage_block_select_out(bsel),
      .wr_data_out(wr_data), .wr_stb_out(wr_stb), .rd_stb_out(rd_stb), .rd_data_in(rdd),
      .act_stb_out(act_stb), .act_code_out(act_code), .busy_out(sbusy));
   swp_assertions u_swp_assertions (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .mst_o(link.mst_o), .mst_oe(link.mst_oe), .slv_o(link.slv_o), .slv_oe(link.slv_oe),
      .line(link.line));
   always #12.5 ref_clk_in = ~ref_clk_in;
   // strobe counts and wire bit decoder: long high is a one
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      n_wr <= n_wr + int'(wr_stb === 1'b1);
      n_rd <= n_rd + int'(rd_stb === 1'b1);
      n_act <= n_act + int'(act_stb === 1'b1);
      n_err <= n_err + int'(err === 1'b1);
      if (link.line === 1'b1) begin
         hi_n <= hi_n + 1;
      end else if (hi_n != 0) begin
         if (hi_n < 60) sh <= {sh[30:0], 1'(hi_n > 20)};
         hi_n <= 0;
      end
      if (cyc == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic run(input logic [7:0] c, input logic [15:0] w);
      int w0, r0, a0, n;
      w0 = n_wr;
      r0 = n_rd;
      a0 = n_act;
      n = 0;
      cmd <= c;
      wd <= w;
      rdd <= w;
      go <= 1'b1;
      @(posedge ref_clk_in);
      go <= 1'b0;
      do begin
         @(negedge ref_clk_in);
         n++;
      end while (done !== 1'b1 && n < 5000);
      @(posedge ref_clk_in);
      chk(n < 5000, 1);
      chk({mbusy, sbusy}, 2'b00);
      if (!c[7]) begin
         chk(sh[9:0], {1'b1, ^c, c});
         chk(n_act - a0, 1);
         chk(act_code, c);
      end else begin
         chk({bsel, addr}, c[5:0]);
         if (c[6]) begin
            chk(sh[29:0], {1'b1, ^c, c, 1'b0, ^w[15:8], w[15:8], ^w[7:0], w[7:0], 1'b0});
            chk(rdata, w);
            chk(n_rd - r0, 1);
         end else begin
            chk(sh[27:0], {1'b1, ^c, c, ^w[15:8], w[15:8], ^w[7:0], w[7:0]});
            chk(wr_data, w);
            chk(n_wr - w0, 1);
         end
      end
   endtask : run
   task automatic complete_run();
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   initial begin
      repeat (6) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      run(8'h85, 16'ha55a);
      run(8'ha3, 16'hff01);
      run(8'hdf, 16'h8001);
      run(8'he0, 16'h7ffe);
      run(8'h12, 16'h0000);
      run(8'h00, 16'h0000);
      chk(n_act, 2);
      chk(n_err, 0);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
